//--- design/ldsr_pkg.sv
// constants for the link diagnostic and subsystem alias register bank
package ldsr_pkg;
  localparam logic [7:0]  OFS_DIAG       = 8'hC8;
  localparam logic [7:0]  OFS_SUBSYS     = 8'hD0;
  localparam logic [7:0]  OFS_SSVID      = 8'h84;
  localparam logic [7:0]  OFS_BAR0       = 8'h10;
  localparam logic [31:0] DIAG_RESET     = 32'h3214_6000;
  localparam logic [31:0] SUBSYS_RESET   = 32'h0000_0000;
  localparam logic [31:0] BAR_RESET      = 32'h0000_0000;
  localparam logic [7:0]  FTS_SEP_RESET  = 8'h32;
  localparam logic [7:0]  FTS_SHR_RESET  = 8'h14;
  localparam logic [2:0]  PHY_REVISION_FIELD_VALUE  = 3'h3;
  localparam logic [4:0]  LINK_NUM_RESET = 5'h00;
  localparam int          FTS_SEP_LSB    = 24;
  localparam int          FTS_SHR_LSB    = 16;
  localparam int          PHY_LSB        = 13;
  localparam int          LINK_LSB       = 8;
  localparam int          BWE_BIT        = 5;
  localparam int          BAR_LSB        = 12;
endpackage

//--- design/ldsr_regs.sv
// link diagnostic control register and subsystem identity alias register
`timescale 1ns/1ns
module ldsr_regs (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        fundResetN,
  input  wire logic        globalResetN,
  input  wire logic        cfgWrite,
  input  wire logic        cfgRead,
  input  wire logic [7:0]  cfgAddr,
  input  wire logic [3:0]  cfgByteEn,
  input  wire logic [31:0] cfgWrData,
  output logic [31:0]      cfgRdData,
  output logic             cfgRdValid,
  input  wire logic        sharedClockConfigBit,
  input  wire logic        l0sExitReq,
  output logic [7:0]       ftsCount,
  output logic             ftsStart,
  output logic [4:0]       linkNumber,
  output logic             baseWindowWriteEnable,
  output logic [31:0]      barValue
);
  logic        mergedRstN;
  logic [7:0]  ftsSep;
  logic [7:0]  ftsShr;
  logic [4:0]  linkNum;
  logic        bwe;
  logic [4:0]  rsvdLow;
  logic [31:0] subsys;
  logic [19:0] barHigh;
  logic [7:0]  next_ftsSep;
  logic [7:0]  next_ftsShr;
  logic [4:0]  next_linkNum;
  logic        next_bwe;
  logic [4:0]  next_rsvdLow;
  logic [31:0] next_subsys;
  logic [19:0] next_barHigh;
  logic [31:0] diagView;
  logic [31:0] rdMux;
  logic [7:0]  ftsSel;
  logic        ccSync1;
  logic        ccSync2;
  logic        reqSync1;
  logic        reqSync2;
  logic        reqPrev;

  // byte-enable merge of one word
  function automatic logic [31:0] mergeBytes(input logic [31:0] oldV, input logic [31:0] newV,
                                             input logic [3:0] be);
    logic [31:0] r;
    r = oldV;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = newV[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a[7:2] == ofs[7:2];
  endfunction

  ldsr_reset_merge u_reset (
    .clk          (clk),
    .rst_n        (rst_n),
    .fundResetN   (fundResetN),
    .globalResetN (globalResetN),
    .mergedRstN   (mergedRstN)
  );

  // register view; reserved 7:6 forced to zero
  assign diagView = {ftsSep, ftsShr, ldsr_pkg::PHY_REVISION_FIELD_VALUE, linkNum, 2'b00, bwe, rsvdLow};

  // next-state of the writable fields
  always_comb begin
    logic [31:0] w;
    w            = 32'h0000_0000;
    next_ftsSep  = ftsSep;
    next_ftsShr  = ftsShr;
    next_linkNum = linkNum;
    next_bwe     = bwe;
    next_rsvdLow = rsvdLow;
    next_subsys  = subsys;
    next_barHigh = barHigh;
    if (cfgWrite && hit(cfgAddr, ldsr_pkg::OFS_DIAG)) begin
      w            = mergeBytes(diagView, cfgWrData, cfgByteEn);
      next_ftsSep  = w[31:24];
      next_ftsShr  = w[23:16];
      next_linkNum = w[12:8];
      next_bwe     = w[ldsr_pkg::BWE_BIT];
      next_rsvdLow = w[4:0]; // loader is expected to keep zero here
    end
    if (cfgWrite && hit(cfgAddr, ldsr_pkg::OFS_SUBSYS)) begin
      next_subsys = mergeBytes(subsys, cfgWrData, cfgByteEn);
    end
    if (cfgWrite && hit(cfgAddr, ldsr_pkg::OFS_BAR0) && bwe) begin
      w            = mergeBytes({barHigh, 12'h000}, cfgWrData, cfgByteEn);
      next_barHigh = w[31:12];
    end
  end

  // all marked fields use the merged reset
  always_ff @(posedge clk or negedge mergedRstN) begin
    if (!mergedRstN) begin
      ftsSep  <= ldsr_pkg::FTS_SEP_RESET;
      ftsShr  <= ldsr_pkg::FTS_SHR_RESET;
      linkNum <= ldsr_pkg::LINK_NUM_RESET;
      bwe     <= 1'b0;
      rsvdLow <= 5'h00;
      subsys  <= ldsr_pkg::SUBSYS_RESET;
      barHigh <= ldsr_pkg::BAR_RESET[31:12];
    end else begin
      ftsSep  <= next_ftsSep;
      ftsShr  <= next_ftsShr;
      linkNum <= next_linkNum;
      bwe     <= next_bwe;
      rsvdLow <= next_rsvdLow;
      subsys  <= next_subsys;
      barHigh <= next_barHigh; // held unless enabled
    end
  end

  // read decode; 84h/86h alias the same word
  always_comb begin
    rdMux = 32'h0000_0000;
    if (hit(cfgAddr, ldsr_pkg::OFS_DIAG)) begin
      rdMux = diagView;
    end else if (hit(cfgAddr, ldsr_pkg::OFS_SUBSYS) || hit(cfgAddr, ldsr_pkg::OFS_SSVID)) begin
      rdMux = subsys;
    end else if (hit(cfgAddr, ldsr_pkg::OFS_BAR0)) begin
      rdMux = {barHigh, 12'h000};
    end
  end

  // shared clock bit and exit request come from the link logic, so synchronise
  assign ftsSel = ccSync2 ? ftsShr : ftsSep;

  always_ff @(posedge clk or negedge mergedRstN) begin
    if (!mergedRstN) begin
      cfgRdData  <= 32'h0000_0000;
      cfgRdValid <= 1'b0;
      ccSync1    <= 1'b0;
      ccSync2    <= 1'b0;
      reqSync1   <= 1'b0;
      reqSync2   <= 1'b0;
      reqPrev    <= 1'b0;
      ftsCount   <= ldsr_pkg::FTS_SEP_RESET;
      ftsStart   <= 1'b0;
    end else begin
      cfgRdData  <= cfgRead ? rdMux : cfgRdData;
      cfgRdValid <= cfgRead;
      ccSync1    <= sharedClockConfigBit;
      ccSync2    <= ccSync1;
      reqSync1   <= l0sExitReq;
      reqSync2   <= reqSync1;
      reqPrev    <= reqSync2;
      ftsCount   <= (reqSync2 && !reqPrev) ? ftsSel : ftsCount;
      ftsStart   <= reqSync2 && !reqPrev;
    end
  end

  assign linkNumber            = linkNum;
  assign baseWindowWriteEnable = bwe;
  assign barValue              = {barHigh, 12'h000};

  a_reserved_zero : assert property (@(posedge clk) disable iff (!mergedRstN)
    cfgRdValid && $past(hit(cfgAddr, ldsr_pkg::OFS_DIAG)) |-> cfgRdData[7:6] == 2'b00)
    else $error("reserved bits 7:6 read nonzero");
  a_bar_locked : assert property (@(posedge clk) disable iff (!mergedRstN)
    !bwe |=> $stable(barValue))
    else $error("bar changed while write enable clear");
  a_bar_write : assert property (@(posedge clk) disable iff (!mergedRstN)
    cfgWrite && hit(cfgAddr, ldsr_pkg::OFS_BAR0) && bwe && cfgByteEn == 4'hF
    |=> barValue == {$past(cfgWrData[31:12]), 12'h000})
    else $error("bar write not taken");
  a_fts_shared : assert property (@(posedge clk) disable iff (!mergedRstN)
    ftsStart && $past(ccSync2) |-> ftsCount == $past(ftsShr))
    else $error("shared clock fts count wrong");
  a_fts_separate : assert property (@(posedge clk) disable iff (!mergedRstN)
    ftsStart && !$past(ccSync2) |-> ftsCount == $past(ftsSep))
    else $error("separate clock fts count wrong");
  a_phy_readonly : assert property (@(posedge clk) disable iff (!mergedRstN)
    cfgRdValid && $past(hit(cfgAddr, ldsr_pkg::OFS_DIAG)) |-> cfgRdData[15:13] == ldsr_pkg::PHY_REVISION_FIELD_VALUE)
    else $error("phy revision not fixed");
  a_alias_id : assert property (@(posedge clk) disable iff (!mergedRstN)
    cfgWrite && hit(cfgAddr, ldsr_pkg::OFS_SUBSYS) && cfgByteEn[3:2] == 2'b11 ##1 cfgRead
    && hit(cfgAddr, ldsr_pkg::OFS_SSVID) |=> cfgRdData[31:16] == $past(cfgWrData[31:16], 2))
    else $error("subsystem id alias mismatch");
  a_alias_vendor : assert property (@(posedge clk) disable iff (!mergedRstN)
    cfgWrite && hit(cfgAddr, ldsr_pkg::OFS_SUBSYS) && cfgByteEn[1:0] == 2'b11 ##1 cfgRead
    && hit(cfgAddr, ldsr_pkg::OFS_SSVID) |=> cfgRdData[15:0] == $past(cfgWrData[15:0], 2))
    else $error("subsystem vendor alias mismatch");
  a_bwe_bit : assert property (@(posedge clk) disable iff (!mergedRstN)
    cfgWrite && hit(cfgAddr, ldsr_pkg::OFS_DIAG) && cfgByteEn[0] |=> bwe == $past(cfgWrData[5]))
    else $error("write enable not bit 5");
  a_reset_defaults : assert property (@(posedge clk) $rose(mergedRstN)
    |-> ftsSep == ldsr_pkg::FTS_SEP_RESET && ftsShr == ldsr_pkg::FTS_SHR_RESET && rsvdLow == 5'h00)
    else $error("defaults not restored");

  c_fts_shared : cover property (@(posedge clk) disable iff (!mergedRstN) ftsStart && ccSync2);
  c_fts_separate : cover property (@(posedge clk) disable iff (!mergedRstN) ftsStart && !ccSync2);
  c_bar_write : cover property (@(posedge clk) disable iff (!mergedRstN)
    bwe && cfgWrite && hit(cfgAddr, ldsr_pkg::OFS_BAR0));
  c_alias_read : cover property (@(posedge clk) disable iff (!mergedRstN) cfgRead && hit(cfgAddr, ldsr_pkg::OFS_SSVID));
endmodule

//--- design/ldsr_reset_merge.sv
// merges the three reset sources into one synchronised active-low reset
`timescale 1ns/1ns
module ldsr_reset_merge (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic fundResetN,
  input  wire logic globalResetN,
  output logic      mergedRstN
);
  logic anyN;
  logic sync1;
  logic sync2;

  // any source asserts asynchronously, release is synchronised
  assign anyN = rst_n & fundResetN & globalResetN;

  always_ff @(posedge clk or negedge anyN) begin
    if (!anyN) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
    end else begin
      sync1 <= 1'b1;
      sync2 <= sync1;
    end
  end

  assign mergedRstN = sync2;
endmodule

//--- tb/test_link_diag_subsystem_regs.sv
// self-checking bench for the link diagnostic and subsystem alias registers
`timescale 1ns/1ns
module test_link_diag_subsystem_regs;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        fundResetN = 1'b1;
  logic        globalResetN = 1'b1;
  logic        cfgWrite = 1'b0;
  logic        cfgRead = 1'b0;
  logic [7:0]  cfgAddr = 8'h00;
  logic [3:0]  cfgByteEn = 4'h0;
  logic [31:0] cfgWrData = 32'h0000_0000;
  logic [31:0] cfgRdData;
  logic        cfgRdValid;
  logic        sharedClockConfigBit = 1'b0;
  logic        l0sExitReq = 1'b0;
  logic [7:0]  ftsCount;
  logic        ftsStart;
  logic [4:0]  linkNumber;
  logic        baseWindowWriteEnable;
  logic [31:0] barValue;
  int          fails = 0;
  int          n_compared = 0;
  int          cycles = 0;

  // 40 ns period
  always #20 clk = ~clk;

  ldsr_regs u_dut (
    .clk                  (clk),
    .rst_n                (rst_n),
    .fundResetN           (fundResetN),
    .globalResetN         (globalResetN),
    .cfgWrite             (cfgWrite),
    .cfgRead              (cfgRead),
    .cfgAddr              (cfgAddr),
    .cfgByteEn            (cfgByteEn),
    .cfgWrData            (cfgWrData),
    .cfgRdData            (cfgRdData),
    .cfgRdValid           (cfgRdValid),
    .sharedClockConfigBit (sharedClockConfigBit),
    .l0sExitReq           (l0sExitReq),
    .ftsCount             (ftsCount),
    .ftsStart             (ftsStart),
    .linkNumber           (linkNumber),
    .baseWindowWriteEnable(baseWindowWriteEnable),
    .barValue             (barValue)
  );

  task automatic tally_and_finish;
    if (fails == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // cut a hang short; the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      tally_and_finish();
    end
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // strobes are high for exactly one cycle, driven 1 ns after the edge
  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge clk);
    #1;
    cfgWrite = 1'b1;
    cfgAddr = a;
    cfgByteEn = be;
    cfgWrData = d;
    @(posedge clk);
    #1;
    cfgWrite = 1'b0;
  endtask

  // read data is valid only in the cycle right after the taking edge;
  // called just after an edge, so a read can follow a write back to back,
  // and one idle edge at the end keeps two reads from touching the strobe at once
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    cfgRead = 1'b1;
    cfgAddr = a;
    @(posedge clk);
    #1;
    cfgRead = 1'b0;
    chk(what, (cfgRdValid === 1'b1) ? cfgRdData : 32'hxxxx_xxxx, exp);
    @(posedge clk);
    #1;
  endtask

  // settle the synchronised clock mode first, then raise the exit request
  task automatic l0s(input logic sh, input logic [7:0] exp);
    int k;
    sharedClockConfigBit = sh;
    repeat (4) @(posedge clk);
    #1;
    l0sExitReq = 1'b1;
    for (k = 0; k < 8 && ftsStart !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    chk("ftsStart", {31'h0000_0000, ftsStart}, 32'h0000_0001);
    chk("ftsCount", {24'h00_0000, ftsCount}, {24'h00_0000, exp});
    l0sExitReq = 1'b0;
    repeat (4) @(posedge clk);
    #1;
  endtask

  // which: 0 power-on, 1 fundamental, 2 global
  task automatic pulse_rst(input int which);
    rst_n = (which != 0);
    fundResetN = (which != 1);
    globalResetN = (which != 2);
    repeat (3) @(posedge clk);
    #1;
    rst_n = 1'b1;
    fundResetN = 1'b1;
    globalResetN = 1'b1;
    repeat (3) @(posedge clk);
    #1;
  endtask

  initial begin
    int r;
    repeat (3) @(posedge clk);
    #1;
    rst_n = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    rd(8'hC8, 32'h3214_6000, "diag default");
    rd(8'hD0, 32'h0000_0000, "alias default");
    rd(8'h40, 32'h0000_0000, "unmapped");
    l0s(1'b0, 8'h32);
    l0s(1'b1, 8'h14);
    // window write enable still clear: bar must not move
    wr(8'h10, 4'hF, 32'hFFFF_FFFF);
    rd(8'h10, 32'h0000_0000, "bar locked");
    // byte 1 all ones, byte 0 sets only enable plus reserved 7:6
    wr(8'hC8, 4'b0011, 32'hFFFF_FFE0); // reserved 4:0 kept zero
    rd(8'hC8, 32'h3214_7F20, "diag low bytes");
    chk("linkNumber", {27'h000_0000, linkNumber}, 32'h0000_001F);
    chk("bwe", {31'h0000_0000, baseWindowWriteEnable}, 32'h0000_0001);
    wr(8'h10, 4'hF, 32'hFFFF_FFFF);
    rd(8'h10, 32'hFFFF_F000, "bar open");
    chk("barValue", barValue, 32'hFFFF_F000);
    wr(8'hC8, 4'b0001, 32'h0000_0000);
    wr(8'h10, 4'hF, 32'h1234_5678);
    rd(8'h10, 32'hFFFF_F000, "bar relocked");
    wr(8'hC8, 4'b1100, 32'h401C_0000);
    rd(8'hC8, 32'h401C_7F00, "diag fts");
    l0s(1'b1, 8'h1C);
    l0s(1'b0, 8'h40);
    // hand the diagnostic register back at its defaults
    wr(8'hC8, 4'hF, 32'h3214_6000);
    rd(8'hC8, 32'h3214_6000, "diag restored");
    wr(8'hD0, 4'hF, 32'hABCD_1234);
    rd(8'h84, 32'hABCD_1234, "vendor alias");
    wr(8'hD0, 4'b1100, 32'h5555_0000);
    rd(8'h86, 32'h5555_1234, "subsys alias");
    rd(8'hD0, 32'h5555_1234, "alias read");
    for (r = 0; r < 3; r++) begin
      wr(8'hC8, 4'hF, 32'h55AA_1F20);
      wr(8'hD0, 4'hF, 32'h1111_2222);
      pulse_rst(r);
      rd(8'hC8, 32'h3214_6000, "diag after reset");
      rd(8'hD0, 32'h0000_0000, "alias after reset");
      chk("ftsCount reset", {24'h00_0000, ftsCount}, 32'h0000_0032);
    end
    tally_and_finish();
  end
endmodule
